// [inc/ibf_pkg.sv]
// ibf_pkg: constants, states and carriers of the two-wire bus core.
// Assumes a 20 MHz system clock; the long hold and half-bit counts derive from it here.
package ibf_pkg;

  // ******************************
  // Timing
  // ******************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int HOLD_LONG_NS = 300;
  // Least time rounds up to whole cycles
  localparam logic [2:0] HOLD_LONG_CYC =
    3'((HOLD_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [2:0] HOLD_SHORT_CYC = 3'h1;
  localparam int HALF_BIT_NS = 5000;
  localparam logic [6:0] HALF_BIT_CYC = 7'(HALF_BIT_NS / CLK_PERIOD_NS);

  // ******************************
  // Framing
  // ******************************
  localparam logic [3:0] LAST_DATA_SLOT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam int MSB_POS = 7;
  localparam int RW_POS = 0;
  localparam logic LINE_IDLE = 1'b1;

  // ******************************
  // Types
  // ******************************
  typedef enum logic [3:0]
  {
    ST_IDLE,
    ST_H_START,
    ST_H_LOW,
    ST_H_HIGH,
    ST_H_STOP_L,
    ST_H_STOP_H,
    ST_C_ADDR,
    ST_C_RX,
    ST_C_TX,
    ST_C_WAIT
  } ibf_state_e;

  typedef struct packed
  {
    logic scl;
    logic sda;
  } ibf_lines_s;

  typedef struct packed
  {
    logic start;
    logic stop;
    logic busy;
  } ibf_cond_s;

endpackage

// [src/ibf_sync.sv]
// ibf_sync: three-stage filter for the two bus lines.
// Assumes raw pin levels asynchronous to clk_sys.
`timescale 1ns/1ns
`default_nettype none
module ibf_sync
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire ibf_pkg::ibf_lines_s pins_i,
  output var ibf_pkg::ibf_lines_s lines_o
);

  logic [1:0] raw;
  logic [1:0] out_w;

  assign raw = pins_i;
  assign lines_o = out_w;

  // ******************************
  // One filter per line
  // ******************************
  for (genvar gi = 0; gi < 2; gi++)
  begin : g_bit
    logic [2:0] sh_q;
    logic [2:0] sh_d;
    logic o_q;
    logic o_d;

    // Output follows once stages two and three agree
    always_comb
    begin
      sh_d = {sh_q[1:0], raw[gi]};
      o_d = (sh_q[1] == sh_q[2]) ? sh_q[1] : o_q;
    end

    always_ff @(posedge clk_sys)
    begin
      if (!rst_b)
      begin
        sh_q <= {3{ibf_pkg::LINE_IDLE}};
        o_q <= ibf_pkg::LINE_IDLE;
      end
      else
      begin
        sh_q <= sh_d;
        o_q <= o_d;
      end
    end

    assign out_w[gi] = o_q;
  end

endmodule
`default_nettype wire

// [src/ibf_cond.sv]
// ibf_cond: start and stop detection and bus busy tracking.
// Assumes filtered line levels on clk_sys.
`timescale 1ns/1ns
`default_nettype none
module ibf_cond
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic en,
  input wire ibf_pkg::ibf_lines_s lines,
  output var ibf_pkg::ibf_cond_s cond_o
);

  ibf_pkg::ibf_lines_s prev_q;
  logic low_seen_q;
  logic low_seen_d;
  ibf_pkg::ibf_cond_s c_q;
  ibf_pkg::ibf_cond_s c_d;

  // ******************************
  // Condition decode
  // ******************************
  always_comb
  begin
    c_d.start = en && prev_q.scl && lines.scl && prev_q.sda && !lines.sda;
    c_d.stop = en && c_q.busy && low_seen_q && prev_q.scl && lines.scl &&
      !prev_q.sda && lines.sda;
    c_d.busy = c_q.busy;
    low_seen_d = low_seen_q;
    if (!en || c_d.stop)
    begin
      c_d.busy = 1'b0;
      low_seen_d = 1'b0;
    end
    else if (c_d.start)
    begin
      c_d.busy = 1'b1;
      low_seen_d = 1'b0;
    end
    else if (!lines.scl)
    begin
      low_seen_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      prev_q <= {2{ibf_pkg::LINE_IDLE}};
      low_seen_q <= 1'b0;
      c_q <= '0;
    end
    else
    begin
      prev_q <= lines;
      low_seen_q <= low_seen_d;
      c_q <= c_d;
    end
  end

  assign cond_o = c_q;

  // ******************************
  // Checks
  // ******************************
  a_stop_after_low: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    c_q.stop |-> $past(low_seen_q) && $past(c_q.busy))
    else $error("stop accepted without clock low since start");

  a_start_shape: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    c_q.start |-> $past(lines.scl) && !$past(lines.sda) ##1 c_q.busy)
    else $error("start not a falling data edge with clock high");

endmodule
`default_nettype wire

// [src/ibf_core.sv]
// ibf_core: two-wire bus framing, arbitration and clock stretching.
// Assumes open-drain pins resolved outside with pull-ups to high.
`timescale 1ns/1ns
`default_nettype none
module ibf_core
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic port_enable_bit,
  input wire logic clock_release_bit,
  input wire logic data_hold_select_bit,
  input wire logic [7:0] own_address_register,
  input wire logic host_go,
  input wire logic host_more,
  input wire logic [7:0] host_tx_byte,
  input wire logic [7:0] client_tx_byte,
  input wire logic scl_i,
  input wire logic sda_i,
  output var logic scl_o,
  output var logic scl_oe,
  output var logic sda_o,
  output var logic sda_oe,
  output var logic [7:0] rx_byte,
  output var logic rx_valid,
  output var logic ack_status,
  output var logic host_done,
  output var logic arb_lost,
  output var logic bus_collision,
  output var logic bus_busy,
  output var logic addressed,
  output var logic read_req
);

  // ******************************
  // Line sampling
  // ******************************
  ibf_pkg::ibf_lines_s pins;
  ibf_pkg::ibf_lines_s lines;
  ibf_pkg::ibf_cond_s cond;

  assign pins = {scl_i, sda_i};

  // Filters ahead of all detection
  ibf_sync u_sync
  (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .pins_i(pins),
    .lines_o(lines)
  );

  // Start, stop and busy tracking
  ibf_cond u_cond
  (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .en(port_enable_bit),
    .lines(lines),
    .cond_o(cond)
  );

  // ******************************
  // State
  // ******************************
  ibf_pkg::ibf_state_e st_q, st_d;
  logic [6:0] cnt_q, cnt_d;
  logic [2:0] hold_q, hold_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] rxb_q, rxb_d;
  logic pend_q, pend_d;
  logic sda_oe_q, sda_oe_d;
  logic host_scl_q, host_scl_d;
  logic stretch_q, stretch_d;
  logic scl_oe_q, scl_oe_d;
  logic scl_p_q;
  logic rxv_q, rxv_d;
  logic ack_q, ack_d;
  logic done_q, done_d;
  logic arb_q, arb_d;
  logic coll_q, coll_d;
  logic busy_q, busy_d;
  logic addr_q, addr_d;
  logic rdreq_q, rdreq_d;
  logic zero_q;
  logic scl_rise;
  logic scl_fall;
  logic host_st;
  logic lose;
  logic bus_idle;
  logic [2:0] hold_len;

  assign scl_rise = lines.scl && !scl_p_q;
  assign scl_fall = !lines.scl && scl_p_q;
  assign host_st = st_q inside {ibf_pkg::ST_H_START, ibf_pkg::ST_H_LOW,
    ibf_pkg::ST_H_HIGH, ibf_pkg::ST_H_STOP_L, ibf_pkg::ST_H_STOP_H};
  assign bus_idle = !cond.busy && lines.scl && lines.sda;
  assign hold_len = data_hold_select_bit ? ibf_pkg::HOLD_LONG_CYC :
    ibf_pkg::HOLD_SHORT_CYC;

  // ******************************
  // Next-state logic
  // ******************************
  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    hold_d = hold_q;
    bit_d = bit_q;
    sh_d = sh_q;
    rxb_d = rxb_q;
    pend_d = pend_q;
    sda_oe_d = sda_oe_q;
    host_scl_d = host_scl_q;
    rxv_d = 1'b0;
    ack_d = ack_q;
    done_d = 1'b0;
    arb_d = 1'b0;
    coll_d = 1'b0;
    addr_d = addr_q;
    rdreq_d = rdreq_q;
    lose = 1'b0;
    // Delayed data change after clock fall
    if (hold_q != 3'h0)
    begin
      hold_d = hold_q - 3'h1;
      if (hold_q == 3'h1)
        sda_oe_d = pend_q;
    end
    case (st_q)
      ibf_pkg::ST_IDLE:
      begin
        if (host_go && bus_idle)
        begin
          sda_oe_d = 1'b1;
          cnt_d = ibf_pkg::HALF_BIT_CYC;
          sh_d = host_tx_byte;
          st_d = ibf_pkg::ST_H_START;
        end
        else if (host_go && !cond.busy && lines.scl && !lines.sda)
          coll_d = 1'b1;
      end
      ibf_pkg::ST_H_START:
      begin
        cnt_d = cnt_q - 7'h1;
        if (cnt_q == 7'h1)
        begin
          host_scl_d = 1'b1;
          bit_d = 4'h0;
          pend_d = !sh_q[ibf_pkg::MSB_POS];
          hold_d = hold_len;
          cnt_d = ibf_pkg::HALF_BIT_CYC;
          st_d = ibf_pkg::ST_H_LOW;
        end
      end
      ibf_pkg::ST_H_LOW:
      begin
        cnt_d = cnt_q - 7'h1;
        if (cnt_q == 7'h1)
        begin
          host_scl_d = 1'b0;
          cnt_d = ibf_pkg::HALF_BIT_CYC;
          st_d = ibf_pkg::ST_H_HIGH;
        end
      end
      ibf_pkg::ST_H_HIGH:
      begin
        if (!lines.scl)
          cnt_d = ibf_pkg::HALF_BIT_CYC;
        else if (scl_rise)
        begin
          if (bit_q == ibf_pkg::ACK_SLOT)
            ack_d = lines.sda;
          else if (!sda_oe_q && !lines.sda)
            lose = 1'b1;
        end
        else
        begin
          cnt_d = cnt_q - 7'h1;
          if (cnt_q == 7'h1)
          begin
            host_scl_d = 1'b1;
            hold_d = hold_len;
            cnt_d = ibf_pkg::HALF_BIT_CYC;
            st_d = ibf_pkg::ST_H_LOW;
            if (bit_q == ibf_pkg::ACK_SLOT)
            begin
              done_d = 1'b1;
              bit_d = 4'h0;
              sh_d = host_tx_byte;
              pend_d = !host_tx_byte[ibf_pkg::MSB_POS];
              if (!host_more)
              begin
                pend_d = 1'b1;
                st_d = ibf_pkg::ST_H_STOP_L;
              end
            end
            else
            begin
              bit_d = bit_q + 4'h1;
              sh_d = {sh_q[6:0], 1'b0};
              pend_d = (bit_q == ibf_pkg::LAST_DATA_SLOT) ? 1'b0 : !sh_q[6];
            end
          end
        end
      end
      ibf_pkg::ST_H_STOP_L:
      begin
        cnt_d = cnt_q - 7'h1;
        if (cnt_q == 7'h1)
        begin
          host_scl_d = 1'b0;
          cnt_d = ibf_pkg::HALF_BIT_CYC;
          st_d = ibf_pkg::ST_H_STOP_H;
        end
      end
      ibf_pkg::ST_H_STOP_H:
      begin
        if (!lines.scl)
          cnt_d = ibf_pkg::HALF_BIT_CYC;
        else
        begin
          cnt_d = cnt_q - 7'h1;
          if (cnt_q == 7'h1)
          begin
            sda_oe_d = 1'b0;
            st_d = ibf_pkg::ST_IDLE;
          end
        end
      end
      ibf_pkg::ST_C_ADDR, ibf_pkg::ST_C_RX:
      begin
        if (scl_rise && bit_q < ibf_pkg::ACK_SLOT)
          sh_d = {sh_q[6:0], lines.sda};
        if (scl_fall)
        begin
          hold_d = hold_len;
          bit_d = bit_q + 4'h1;
          if (bit_q == ibf_pkg::LAST_DATA_SLOT)
          begin
            hold_d = 3'h0;
            if (st_q == ibf_pkg::ST_C_RX)
            begin
              pend_d = 1'b1;
              hold_d = hold_len;
              rxb_d = sh_q;
              rxv_d = 1'b1;
            end
            else if (sh_q[7:1] == own_address_register[7:1])
            begin
              pend_d = 1'b1;
              hold_d = hold_len;
              addr_d = 1'b1;
              rdreq_d = sh_q[ibf_pkg::RW_POS];
            end
            else
              st_d = ibf_pkg::ST_C_WAIT;
          end
          else if (bit_q == ibf_pkg::ACK_SLOT)
          begin
            bit_d = 4'h0;
            pend_d = 1'b0;
            st_d = ibf_pkg::ST_C_RX;
            if (st_q == ibf_pkg::ST_C_ADDR && rdreq_q)
            begin
              sh_d = client_tx_byte;
              pend_d = !client_tx_byte[ibf_pkg::MSB_POS];
              st_d = ibf_pkg::ST_C_TX;
            end
          end
          else
            hold_d = 3'h0;
        end
      end
      ibf_pkg::ST_C_TX:
      begin
        if (scl_rise && bit_q == ibf_pkg::ACK_SLOT && lines.sda)
          st_d = ibf_pkg::ST_C_WAIT;
        else if (scl_rise && bit_q != ibf_pkg::ACK_SLOT &&
          !sda_oe_q && !lines.sda)
          lose = 1'b1;
        if (scl_fall)
        begin
          hold_d = hold_len;
          bit_d = bit_q + 4'h1;
          sh_d = {sh_q[6:0], 1'b0};
          pend_d = (bit_q == ibf_pkg::LAST_DATA_SLOT) ? 1'b0 : !sh_q[6];
          if (bit_q == ibf_pkg::ACK_SLOT)
          begin
            bit_d = 4'h0;
            sh_d = client_tx_byte;
            pend_d = !client_tx_byte[ibf_pkg::MSB_POS];
          end
        end
      end
      ibf_pkg::ST_C_WAIT:
        sda_oe_d = 1'b0;
      default:
        st_d = ibf_pkg::ST_IDLE;
    endcase
    // Lost arbitration: let go of both lines
    if (lose)
    begin
      sda_oe_d = 1'b0;
      host_scl_d = 1'b0;
      hold_d = 3'h0;
      arb_d = 1'b1;
      coll_d = 1'b1;
      st_d = ibf_pkg::ST_C_WAIT;
    end
    // Conditions from other parties restart client logic
    if (!host_st && (cond.start || cond.stop))
    begin
      sda_oe_d = 1'b0;
      hold_d = 3'h0;
      addr_d = 1'b0;
      rdreq_d = 1'b0;
      // Start's own clock fall wraps the count to zero
      bit_d = 4'hF;
      st_d = cond.start ? ibf_pkg::ST_C_ADDR : ibf_pkg::ST_IDLE;
    end
    stretch_d = !clock_release_bit && (stretch_q || !lines.scl);
    busy_d = cond.busy;
    if (!port_enable_bit)
    begin
      st_d = ibf_pkg::ST_IDLE;
      sda_oe_d = 1'b0;
      host_scl_d = 1'b0;
      stretch_d = 1'b0;
      hold_d = 3'h0;
      addr_d = 1'b0;
      rdreq_d = 1'b0;
    end
    scl_oe_d = host_scl_d || stretch_d;
  end

  // ******************************
  // Registers
  // ******************************
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      st_q <= ibf_pkg::ST_IDLE;
      cnt_q <= 7'h00;
      hold_q <= 3'h0;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      rxb_q <= 8'h00;
      pend_q <= 1'b0;
      sda_oe_q <= 1'b0;
      host_scl_q <= 1'b0;
      stretch_q <= 1'b0;
      scl_oe_q <= 1'b0;
      scl_p_q <= ibf_pkg::LINE_IDLE;
      rxv_q <= 1'b0;
      ack_q <= 1'b0;
      done_q <= 1'b0;
      arb_q <= 1'b0;
      coll_q <= 1'b0;
      busy_q <= 1'b0;
      addr_q <= 1'b0;
      rdreq_q <= 1'b0;
      zero_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      hold_q <= hold_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      rxb_q <= rxb_d;
      pend_q <= pend_d;
      sda_oe_q <= sda_oe_d;
      host_scl_q <= host_scl_d;
      stretch_q <= stretch_d;
      scl_oe_q <= scl_oe_d;
      scl_p_q <= lines.scl;
      rxv_q <= rxv_d;
      ack_q <= ack_d;
      done_q <= done_d;
      arb_q <= arb_d;
      coll_q <= coll_d;
      busy_q <= busy_d;
      addr_q <= addr_d;
      rdreq_q <= rdreq_d;
      zero_q <= 1'b0;
    end
  end

  // Pin drive levels are always low
  assign scl_o = zero_q;
  assign sda_o = zero_q;
  assign scl_oe = scl_oe_q;
  assign sda_oe = sda_oe_q;
  assign rx_byte = rxb_q;
  assign rx_valid = rxv_q;
  assign ack_status = ack_q;
  assign host_done = done_q;
  assign arb_lost = arb_q;
  assign bus_collision = coll_q;
  assign bus_busy = busy_q;
  assign addressed = addr_q;
  assign read_req = rdreq_q;

  // ******************************
  // Checks
  // ******************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b || !port_enable_bit);

  sequence s_long_hold;
    $stable(sda_oe_q) [*6];
  endsequence

  a_enable_off: assert property (disable iff (!rst_b)
    !port_enable_bit |=> !scl_oe_q && !sda_oe_q && st_q == ibf_pkg::ST_IDLE)
    else $error("lines not released with enable clear");
  a_hold_long: assert property (
    $rose(host_scl_q) && $past(data_hold_select_bit) |-> s_long_hold)
    else $error("data changed inside long hold time");
  a_stretch_hold: assert property (
    !clock_release_bit && !lines.scl ##1 !clock_release_bit
    |-> scl_oe_q ##1 scl_oe_q)
    else $error("clock not held while release bit clear");
  a_idle_release: assert property (
    st_q == ibf_pkg::ST_IDLE && clock_release_bit |=> !scl_oe_q)
    else $error("clock held while idle and released");
  a_busy_guard: assert property (
    st_q == ibf_pkg::ST_IDLE && host_go && cond.busy
    |=> st_q != ibf_pkg::ST_H_START && !sda_oe_q)
    else $error("start begun on busy bus");
  a_start_coll: assert property (
    st_q == ibf_pkg::ST_IDLE && host_go && !cond.busy && lines.scl &&
    !lines.sda |=> bus_collision && st_q == ibf_pkg::ST_IDLE)
    else $error("start collision not flagged");
  a_arb_release: assert property (
    st_q == ibf_pkg::ST_H_HIGH && scl_rise && bit_q != ibf_pkg::ACK_SLOT &&
    !sda_oe_q && !lines.sda |=> arb_lost && bus_collision && !sda_oe_q &&
    !host_scl_q ##1 st_q == ibf_pkg::ST_C_WAIT || cond.start)
    else $error("lost arbitration without release");
  a_ack_release: assert property (
    st_q == ibf_pkg::ST_H_HIGH && bit_q == ibf_pkg::ACK_SLOT |-> !sda_oe_q)
    else $error("data driven during acknowledge slot");
  a_addr_miss: assert property (
    st_q == ibf_pkg::ST_C_ADDR && scl_fall &&
    bit_q == ibf_pkg::LAST_DATA_SLOT &&
    sh_q[7:1] != own_address_register[7:1] && !cond.start && !cond.stop
    |=> st_q == ibf_pkg::ST_C_WAIT && !addressed)
    else $error("address mismatch still accepted");

endmodule
`default_nettype wire

// [test/ibf_bus_model.sv]
// ibf_bus_model: far-side party on the two-wire bus, host or client.
// Assumes pull-ups: a released line reads high on the wired pair.
`timescale 1ns/1ns
`default_nettype none
module ibf_bus_model
(
  input wire logic scl,
  input wire logic sda,
  output var logic scl_pull,
  output var logic sda_pull
);
  // Low half widened so the synchronised device can answer in time
  localparam int LOW_NS = 600;
  localparam int HIGH_NS = 200;

  initial
  begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end

  // One clock: data set while low, sampled at the rise
  task automatic bit_io(input logic v, output logic s);
    #(LOW_NS / 2) sda_pull = !v;
    #(LOW_NS / 2) scl_pull = 1'b0;
    wait (scl === 1'b1);
    s = sda;
    #HIGH_NS scl_pull = 1'b1;
  endtask

  // Start or restart: data falls while clock high
  task automatic start();
    #(LOW_NS / 2) sda_pull = 1'b0;
    #(LOW_NS / 2) scl_pull = 1'b0;
    wait (scl === 1'b1);
    #HIGH_NS sda_pull = 1'b1;
    #HIGH_NS scl_pull = 1'b1;
  endtask

  // Data low then high with clock high and no low between
  task automatic glitch();
    #(LOW_NS / 2) sda_pull = 1'b1;
    #HIGH_NS sda_pull = 1'b0;
    #HIGH_NS;
  endtask

  // Stop: data rises while clock high
  task automatic stop();
    #(LOW_NS / 2) sda_pull = 1'b1;
    #(LOW_NS / 2) scl_pull = 1'b0;
    wait (scl === 1'b1);
    #HIGH_NS sda_pull = 1'b0;
    #HIGH_NS;
  endtask

  // Nine clocks, MSB first; ninth releases or acks
  task automatic xfer(input logic [7:0] tx, input logic ack_in,
                      output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(ack_in, ack);
  endtask

  // Client receiving from a device host, acks the byte
  task automatic client_rx(output logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      @(posedge scl);
      b[i] = sda;
    end
    @(negedge scl);
    #100 sda_pull = 1'b1;
    @(negedge scl);
    #400 sda_pull = 1'b0;
  endtask

  // Second transmitter pulls data low on the second bit
  task automatic contend();
    @(negedge scl);
    @(negedge scl);
    #100 sda_pull = 1'b1;
    #8000 sda_pull = 1'b0;
  endtask
endmodule
`default_nettype wire

// [test/tb_ibf_core.sv]
// tb_ibf_core: self-checking bench for the two-wire bus core.
// Assumes ibf_bus_model on the far side and pull-ups on both lines.
`timescale 1ns/1ns
`default_nettype none
module tb_ibf_core;
  logic clk_sys, rst_b, crb, hsel, go, pen;
  logic [7:0] tx_b, rx_byte, got_rx, mb;
  logic scl_o, scl_oe, sda_o, sda_oe, rx_valid, ack_status, host_done;
  logic arb_lost, bus_collision, bus_busy, addressed, read_req;
  logic m_scl, m_sda, ma, scl_w, sda_w, sda_oe_p;
  int errors, n_checks, arb_n, col_n, done_n, hi_n, early, n;

  // Wired pair with pull-ups
  assign scl_w = !(scl_oe | m_scl);
  assign sda_w = !(sda_oe | m_sda);

  ibf_core DUT (.clk_sys(clk_sys), .rst_b(rst_b), .port_enable_bit(pen),
    .clock_release_bit(crb), .data_hold_select_bit(hsel),
    .own_address_register(8'hA4), .host_go(go), .host_more(1'b0),
    .host_tx_byte(tx_b), .client_tx_byte(8'h5A), .scl_i(scl_w),
    .sda_i(sda_w), .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o),
    .sda_oe(sda_oe), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .ack_status(ack_status), .host_done(host_done), .arb_lost(arb_lost),
    .bus_collision(bus_collision), .bus_busy(bus_busy),
    .addressed(addressed), .read_req(read_req));

  ibf_bus_model far (.scl(scl_w), .sda(sda_w), .scl_pull(m_scl),
    .sda_pull(m_sda));

  // ******************************
  // Clock, monitors, checks
  // ******************************
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Pulse capture and data hold watch
  always @(posedge clk_sys)
  begin
    if (rx_valid === 1'b1) got_rx <= rx_byte;
    if (arb_lost === 1'b1) arb_n++;
    if (bus_collision === 1'b1) col_n++;
    if (host_done === 1'b1) done_n++;
    if (scl_oe === 1'b1 && sda_oe !== sda_oe_p && hi_n < 5) early++;
    hi_n = (scl_oe === 1'b1) ? hi_n + 1 : 0;
    sda_oe_p <= sda_oe;
  end

  task automatic chk(input string what, input logic [7:0] e,
                     input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch %s exp %h got %h", what, e, g);
    end
  endtask

  task automatic chkb(input string what, input logic e, input logic g);
    chk(what, {7'h00, e}, {7'h00, g});
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge clk_sys);
    #5;
  endtask

  task automatic go_byte(input logic [7:0] b);
    tick(1);
    tx_b = b;
    go = 1'b1;
    tick(1);
    go = 1'b0;
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ******************************
  // Scenarios
  // ******************************
  task automatic t_reset();
    chkb("scl_oe", 1'b0, scl_oe);
    chkb("sda_oe", 1'b0, sda_oe);
    chkb("busy", 1'b0, bus_busy);
    chkb("scl_o", 1'b0, scl_o);
    chkb("sda_o", 1'b0, sda_o);
    $display("test reset done");
  endtask

  task automatic t_client_write();
    far.glitch();
    tick(20);
    chkb("short stop", 1'b1, bus_busy);
    go_byte(8'hA4);
    tick(20);
    chkb("go refused", 1'b0, sda_oe);
    crb = 1'b0;
    far.start();
    tick(40);
    chkb("stretch oe", 1'b1, scl_oe);
    chkb("stretch line", 1'b0, scl_w);
    fork
      far.xfer(8'hA4, 1'b1, mb, ma);
      begin
        tick(60);
        crb = 1'b1;
      end
    join
    chkb("addr ack", 1'b0, ma);
    chkb("addressed", 1'b1, addressed);
    chkb("read_req", 1'b0, read_req);
    far.xfer(8'h3C, 1'b1, mb, ma);
    chk("rx byte", 8'h3C, got_rx);
    chkb("data ack", 1'b0, ma);
    far.stop();
    tick(20);
    chkb("busy", 1'b0, bus_busy);
    $display("test client_write done");
  endtask

  task automatic t_client_read();
    far.start();
    far.xfer(8'hA6, 1'b1, mb, ma);
    chkb("other nack", 1'b1, ma);
    chkb("other addr", 1'b0, addressed);
    far.start();
    far.xfer(8'hA5, 1'b1, mb, ma);
    chkb("read_req", 1'b1, read_req);
    far.xfer(8'hFF, 1'b0, mb, ma);
    chk("read 1", 8'h5A, mb);
    far.xfer(8'hFF, 1'b1, mb, ma);
    chk("read 2", 8'h5A, mb);
    far.stop();
    tick(20);
    chkb("addressed", 1'b0, addressed);
    $display("test client_read done");
  endtask

  task automatic t_host_tx();
    hsel = 1'b1;
    early = 0;
    done_n = 0;
    fork
      far.client_rx(mb);
      go_byte(8'h96);
    join
    for (n = 0; n < 1000 && bus_busy !== 1'b0; n++) tick(1);
    chk("host byte", 8'h96, mb);
    chkb("ack", 1'b0, ack_status);
    chk("done", 8'h01, 8'(done_n));
    chk("early", 8'h00, 8'(early));
    chkb("idle", 1'b0, bus_busy);
    $display("test host_tx done");
  endtask

  task automatic t_arbitration();
    arb_n = 0;
    col_n = 0;
    fork
      far.contend();
      go_byte(8'h7F);
    join
    chk("arb", 8'h01, 8'(arb_n));
    chk("collision", 8'h01, 8'(col_n));
    chkb("scl_oe", 1'b0, scl_oe);
    chkb("sda_oe", 1'b0, sda_oe);
    tick(20);
    chkb("idle", 1'b0, bus_busy);
    $display("test arbitration done");
  endtask

  task automatic t_disable();
    crb = 1'b0;
    far.start();
    tick(20);
    chkb("hold before off", 1'b1, scl_oe);
    pen = 1'b0;
    tick(2);
    chkb("off scl_oe", 1'b0, scl_oe);
    chkb("off busy", 1'b0, bus_busy);
    crb = 1'b1;
    pen = 1'b1;
    far.stop();
    tick(20);
    $display("test disable done");
  endtask

  // Main sequence
  initial
  begin
    rst_b = 1'b0;
    pen = 1'b1;
    crb = 1'b1;
    hsel = 1'b0;
    go = 1'b0;
    tx_b = 8'h00;
    tick(2);
    rst_b = 1'b1;
    tick(6);
    t_reset();
    t_client_write();
    t_client_read();
    t_host_tx();
    t_arbitration();
    t_disable();
    wrap_up();
  end

  // Watchdog well beyond the expected run
  initial
  begin
    #3000000;
    errors++;
    wrap_up();
  end
endmodule
`default_nettype wire
